// ### hdl/ebb_pkg.sv
package ebb_pkg;

    // ----------------------------------------
    // Control word bit positions (bits 0-3 low true, bits 4-7 high true)
    // ----------------------------------------
    localparam int CW_GLOBAL = 0;
    localparam int CW_PATTERN = 1;
    localparam int CW_HALT = 2;
    localparam int CW_STIM = 3;
    localparam int CW_BYTE_MUX = 4;
    localparam int CW_STATUS_MUX = 5;
    localparam int CW_CLK_SRC = 6;
    localparam int CW_DATA_SRC = 7;

    // ----------------------------------------
    // Status word bit positions
    // ----------------------------------------
    localparam int SW_ANY = 0;
    localparam int SW_PATTERN = 1;
    localparam int SW_ANALYSIS = 2;
    localparam int SW_STIM = 14;
    localparam int SW_HILO = 15;

    // ----------------------------------------
    // Host address map
    // ----------------------------------------
    localparam int ADDR_STATUS_BIT = 6;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    // All breaks disabled, byte and status muxing enabled, until software writes a control word
    localparam logic [7:0] CW_RESET = 8'hFF;
    localparam logic [15:0] SW_RESET = 16'h3FFF;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // Arbitrary identification code, no meaning beyond this design
    localparam logic [7:0] ID_CODE = 8'h5A;

endpackage : ebb_pkg

// ### hdl/ebb_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Read mode with strobe low: board may drive read data.
// - Analyzer transfers happen on falling edge of transfer_clock_n.
// - Pattern RAM write enable low writes, high reads.
// - Control word write loads buffered write data into control word.
// - Pattern RAM data comes from write data bits 0 to 5.
// - Halt qualify clock captures halt_qualified level before each trace.
// - Identity select returns the preprocessor identification code.
// - Emulator identity clock latches the attached emulator identity.
// - Status select presents the status word to the analyzer.
// - Byte mux output feeds pod 2 bits 4-11, 8 or 16 bit.
// - Data/status mux output feeds pod 2 bits 12-19.
// - halt_qualified high enables halt breaks, low disables them.
// - Stimulus rising edge captures stimulus break enable to decide break.
// - Break strobe clocks pattern found into break capture.
// - Sixteen-bit status word, readable by analyzer and host.
// - Status bits 0-2 low on any, pattern or analysis break.
// - Bits 3-6 high when cables present; bit 7 low when bus connected.
// - Bits 8-13 low when the six pattern slices match.
// - Bit 14 high after stimulus break; bit 15 high when multiplexing the upper byte.
// - Control bits low true: global, pattern, halt, stimulus break enables.
// - Bits 4 and 5 choose data or byte mux, data or status.
// - Bit 6 picks sample clock, bit 7 picks load address or data.
// - A qualified break drives break_request low.
module ebb_top (
    // Clocks and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic transfer_clock_n,
    // Host bus
    input wire logic host_strobe_n,
    input wire logic cpu_write_mode_n,
    input wire logic address_valid_strobe_n,
    input wire logic pattern_ram_write_enable_n,
    input wire logic control_word_write_n,
    input wire logic [7:0] buffered_write_data,
    input wire logic [6:0] host_address,
    input wire logic break_reset_n,
    output logic [15:0] host_data_out,
    output logic host_data_oe_n,
    // Emulation bus
    input wire logic [17:0] emu_address,
    input wire logic [15:0] emu_data,
    input wire logic [7:0] emu_status,
    input wire logic emu_byte_upper_n,
    input wire logic analysis_clock,
    input wire logic pv_strobe_n,
    input wire logic [4:0] cable_sense_n,
    input wire logic [7:0] emulator_identity,
    // Break generation
    input wire logic break_strobe,
    input wire logic stimulus_event,
    input wire logic interface_halt_pair,
    input wire logic interface_halt_pair_n,
    output logic break_request_n,
    // Analyzer pod 2
    output logic [7:0] data_byte_mux_out,
    output logic [7:0] data_status_mux_out,
    // Analyzer link, transfer_clock_n domain
    input wire logic identity_select_n,
    input wire logic preprocessor_status_select_n,
    input wire logic halt_qualify_clock_n,
    input wire logic halt_qualified,
    input wire logic emulator_identity_clock_n,
    output logic [7:0] link_data,
    output logic link_data_oe_n
);

    // ----------------------------------------
    // State types
    // ----------------------------------------
    typedef struct packed {
        logic strobe_n;
        logic wmode_n;
        logic avs_n;
        logic pwe_n;
        logic cww_n;
        logic brk_stb;
        logic stim;
        logic halt_p;
        logic halt_m;
        logic brst_n;
        logic anal_clk;
        logic pv_stb_n;
        logic bup_n;
        logic [4:0] sense_n;
        logic [7:0] wd;
        logic [6:0] addr;
        logic [17:0] ea;
        logic [15:0] ed;
        logic [7:0] es;
        logic halt_en;
    } ebb_pins_s;

    typedef struct packed {
        ebb_pins_s s1;
        ebb_pins_s s2;
        ebb_pins_s prev;
        logic [7:0] cw;
        logic [6:0] load_addr;
        logic [63:0][5:0] ram;
        logic pat_brk;
        logic halt_brk;
        logic stim_brk;
        logic brk_n;
        logic hilo;
        logic [15:0] status;
        logic [7:0] mux_lo;
        logic [7:0] mux_hi;
        logic [15:0] hd_out;
        logic hd_oe_n;
    } ebb_host_s;

    typedef struct packed {
        logic [15:0] st1;
        logic [15:0] st2;
        logic [7:0] ei1;
        logic [7:0] ei2;
        logic [7:0] emu_id;
        logic halt_en;
        logic hi;
        logic [7:0] data;
        logic oe_n;
    } ebb_link_s;

    ebb_host_s h;
    ebb_host_s next_h;
    ebb_link_s l;
    ebb_link_s next_l;
    ebb_pins_s pins;
    logic [1:0] hrs;
    logic [1:0] lrs;
    logic rst_n;
    logic lrst_n;
    logic [5:0] match;
    logic pattern_found;
    logic halt_level;
    logic halt_prev;

    // ----------------------------------------
    // Reset release, one per domain
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            hrs <= ebb_pkg::SYNC_RESET;
        else
            hrs <= {hrs[0], 1'b1};
    end

    always_ff @(negedge transfer_clock_n or negedge rstn)
    begin
        if (!rstn)
            lrs <= ebb_pkg::SYNC_RESET;
        else
            lrs <= {lrs[0], 1'b1};
    end

    assign rst_n = hrs[1];
    assign lrst_n = lrs[1];

    // ----------------------------------------
    // Host domain
    // ----------------------------------------
    // Buses are stable around their strobes, so a plain two-stage
    // capture is safe; the strobes are only acted on once synchronised.
    assign pins = '{
        strobe_n: host_strobe_n,
        wmode_n: cpu_write_mode_n,
        avs_n: address_valid_strobe_n,
        pwe_n: pattern_ram_write_enable_n,
        cww_n: control_word_write_n,
        brk_stb: break_strobe,
        stim: stimulus_event,
        halt_p: interface_halt_pair,
        halt_m: interface_halt_pair_n,
        brst_n: break_reset_n,
        anal_clk: analysis_clock,
        pv_stb_n: pv_strobe_n,
        bup_n: emu_byte_upper_n,
        sense_n: cable_sense_n,
        wd: buffered_write_data,
        addr: host_address,
        ea: emu_address,
        ed: emu_data,
        es: emu_status,
        halt_en: l.halt_en
    };

    // Pattern RAM is a lookup per slice: the bus value indexes it
    always_comb
    begin
        match[0] = h.ram[h.s2.ea[5:0]][0];
        match[1] = h.ram[h.s2.ea[11:6]][1];
        match[2] = h.ram[h.s2.ea[17:12]][2];
        match[3] = h.ram[h.s2.ed[5:0]][3];
        match[4] = h.ram[h.s2.ed[13:8]][4];
        match[5] = h.ram[h.s2.es[5:0]][5];
        pattern_found = &match;
        halt_level = h.s2.halt_p & ~h.s2.halt_m;
        halt_prev = h.prev.halt_p & ~h.prev.halt_m;
    end

    always_comb
    begin
        logic samp;
        logic [15:0] src;
        logic ev_pat;
        logic ev_halt;
        logic ev_stim;
        samp = 1'b0;
        src = 16'h0000;
        ev_pat = 1'b0;
        ev_halt = 1'b0;
        ev_stim = 1'b0;
        next_h = h;
        next_h.s1 = pins;
        next_h.s2 = h.s1;
        next_h.prev = h.s2;
        if (h.s2.cww_n == 1'b0 && h.prev.cww_n == 1'b1)
            next_h.cw = h.s2.wd;
        if (!h.s2.avs_n)
            next_h.load_addr = h.s2.addr;
        if (!h.s2.strobe_n && !h.s2.wmode_n && !h.s2.avs_n && !h.s2.pwe_n
            && !h.s2.addr[ebb_pkg::ADDR_STATUS_BIT])
            next_h.ram[h.s2.addr[5:0]] = h.s2.wd[5:0];
        ev_pat = h.s2.brk_stb & ~h.prev.brk_stb & pattern_found
            & ~h.cw[ebb_pkg::CW_GLOBAL] & ~h.cw[ebb_pkg::CW_PATTERN];
        ev_halt = halt_level & ~halt_prev & h.s2.halt_en
            & ~h.cw[ebb_pkg::CW_GLOBAL] & ~h.cw[ebb_pkg::CW_HALT];
        ev_stim = h.s2.stim & ~h.prev.stim
            & ~h.cw[ebb_pkg::CW_GLOBAL] & ~h.cw[ebb_pkg::CW_STIM];
        // Break reset clears, but a break in the same cycle still lands
        if (!h.s2.brst_n)
        begin
            next_h.pat_brk = 1'b0;
            next_h.halt_brk = 1'b0;
            next_h.stim_brk = 1'b0;
        end
        if (ev_pat)
            next_h.pat_brk = 1'b1;
        if (ev_halt)
            next_h.halt_brk = 1'b1;
        if (ev_stim)
            next_h.stim_brk = 1'b1;
        next_h.brk_n = ~(next_h.pat_brk | next_h.halt_brk | next_h.stim_brk);
        // Routing samples on the selected clock source
        if (h.cw[ebb_pkg::CW_CLK_SRC])
            samp = h.s2.anal_clk & ~h.prev.anal_clk;
        else
            samp = ~h.s2.pv_stb_n & h.prev.pv_stb_n;
        if (h.cw[ebb_pkg::CW_DATA_SRC])
            src = h.s2.ed;
        else
            src = {9'h000, h.load_addr};
        if (samp)
        begin
            if (h.cw[ebb_pkg::CW_BYTE_MUX] && !h.s2.bup_n)
                next_h.mux_lo = src[15:8];
            else
                next_h.mux_lo = src[7:0];
            if (h.cw[ebb_pkg::CW_STATUS_MUX])
                next_h.mux_hi = h.s2.es;
            else
                next_h.mux_hi = src[15:8];
            next_h.hilo = h.cw[ebb_pkg::CW_BYTE_MUX] & ~h.s2.bup_n;
        end
        next_h.status = {h.hilo, h.stim_brk, ~match, h.s2.sense_n[4],
            ~h.s2.sense_n[3:0], ~(h.halt_brk | h.stim_brk), ~h.pat_brk,
            ~(h.pat_brk | h.halt_brk | h.stim_brk)};
        // Drive only once the host has let go of the bus
        next_h.hd_oe_n = ~(!h.s2.strobe_n && h.s2.wmode_n && !h.s2.avs_n
            && (h.s2.pwe_n || h.s2.addr[ebb_pkg::ADDR_STATUS_BIT]));
        if (h.s2.addr[ebb_pkg::ADDR_STATUS_BIT])
            next_h.hd_out = h.status;
        else
            next_h.hd_out = {10'h000, h.ram[h.s2.addr[5:0]]};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            h <= '0;
            h.cw <= ebb_pkg::CW_RESET;
            h.brk_n <= 1'b1;
            h.status <= ebb_pkg::SW_RESET;
            h.hd_oe_n <= 1'b1;
        end
        else
            h <= next_h;
    end

    // ----------------------------------------
    // Link domain, falling edge of transfer clock
    // ----------------------------------------
    // Status bits are independent flags, each crossing as its own level
    always_comb
    begin
        next_l = l;
        next_l.st1 = h.status;
        next_l.st2 = l.st1;
        next_l.ei1 = emulator_identity;
        next_l.ei2 = l.ei1;
        if (!emulator_identity_clock_n)
            next_l.emu_id = l.ei2;
        if (!halt_qualify_clock_n)
            next_l.halt_en = halt_qualified;
        if (!identity_select_n)
        begin
            next_l.data = l.hi ? l.emu_id : ebb_pkg::ID_CODE;
            next_l.oe_n = 1'b0;
            next_l.hi = ~l.hi;
        end
        else if (!preprocessor_status_select_n)
        begin
            next_l.data = l.hi ? l.st2[15:8] : l.st2[7:0];
            next_l.oe_n = 1'b0;
            next_l.hi = ~l.hi;
        end
        else
        begin
            next_l.oe_n = 1'b1;
            next_l.hi = 1'b0;
        end
    end

    always_ff @(negedge transfer_clock_n or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            l <= '0;
            l.st1 <= ebb_pkg::SW_RESET;
            l.st2 <= ebb_pkg::SW_RESET;
            l.oe_n <= 1'b1;
        end
        else
            l <= next_l;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign host_data_out = h.hd_out;
    assign host_data_oe_n = h.hd_oe_n;
    assign break_request_n = h.brk_n;
    assign data_byte_mux_out = h.mux_lo;
    assign data_status_mux_out = h.mux_hi;
    assign link_data = l.data;
    assign link_data_oe_n = l.oe_n;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_cw_load;
        @(posedge clock) disable iff (!rst_n)
        $fell(h.s2.cww_n) |=> h.cw == $past(h.s2.wd);
    endproperty
    a_cw_load: assert property (p_cw_load) else $error("control word not loaded");

    property p_ram_write;
        @(posedge clock) disable iff (!rst_n)
        (!h.s2.strobe_n && !h.s2.wmode_n && !h.s2.avs_n && !h.s2.pwe_n && !h.s2.addr[6])
        |=> h.ram[$past(h.s2.addr[5:0])] == $past(h.s2.wd[5:0]);
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("pattern RAM write lost");

    property p_break_out;
        @(posedge clock) disable iff (!rst_n)
        (h.pat_brk || h.halt_brk || h.stim_brk) |-> !break_request_n;
    endproperty
    a_break_out: assert property (p_break_out) else $error("break request not low");

    property p_sticky;
        @(posedge clock) disable iff (!rst_n)
        (h.pat_brk && h.s2.brst_n) |=> h.pat_brk;
    endproperty
    a_sticky: assert property (p_sticky) else $error("pattern break flag lost");

    sequence s_stim_edge;
        $rose(h.s2.stim) && !h.cw[0] && !h.cw[3];
    endsequence
    property p_stim;
        @(posedge clock) disable iff (!rst_n)
        s_stim_edge |=> h.stim_brk ##1 (h.status[14] && !h.status[0]);
    endproperty
    a_stim: assert property (p_stim) else $error("stimulus break not reported");

    property p_pattern;
        @(posedge clock) disable iff (!rst_n)
        ($rose(h.s2.brk_stb) && pattern_found && !h.cw[0] && !h.cw[1]) |=> h.pat_brk;
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern break not captured");

    property p_halt_qual;
        @(negedge transfer_clock_n) disable iff (!lrst_n)
        !halt_qualify_clock_n |=> l.halt_en == $past(halt_qualified);
    endproperty
    a_halt_qual: assert property (p_halt_qual) else $error("halt level not captured");

    property p_identity;
        @(negedge transfer_clock_n) disable iff (!lrst_n)
        (!identity_select_n && !l.hi) |=> (link_data == ebb_pkg::ID_CODE && !link_data_oe_n);
    endproperty
    a_identity: assert property (p_identity) else $error("identity code not returned");

endmodule : ebb_top

`default_nettype wire

// ### testbench/ebb_analyzer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Analyzer side of the link
// ----------------------------------------
module ebb_analyzer_model (
    // Link clock and qualifiers
    output logic transfer_clock_n,
    output logic identity_select_n,
    output logic preprocessor_status_select_n,
    output logic halt_qualify_clock_n,
    output logic halt_qualified,
    output logic emulator_identity_clock_n,
    // Link read data
    input wire logic [7:0] link_data,
    input wire logic link_data_oe_n
);
    // Clock stands high outside frames, so nothing moves between them
    initial
    begin
        transfer_clock_n = 1'b1;
        identity_select_n = 1'b1;
        preprocessor_status_select_n = 1'b1;
        halt_qualify_clock_n = 1'b1;
        halt_qualified = 1'b0;
        emulator_identity_clock_n = 1'b1;
    end
    // One link cycle: qualifiers change after the rise, taken at the fall
    task automatic tick(input logic id_n, input logic st_n, input logic warm,
                        output logic [8:0] got);
        identity_select_n = id_n;
        preprocessor_status_select_n = st_n;
        halt_qualify_clock_n = ~warm;
        halt_qualified = warm;
        emulator_identity_clock_n = ~warm;
        #62.5 transfer_clock_n = 1'b0;
        #60 got = {link_data_oe_n, link_data};
        #2.5 transfer_clock_n = 1'b1;
    endtask : tick
    // Warm-up cycles let status bits cross, then two selected cycles and one idle
    task automatic frame(input logic want_id, output logic [8:0] b0, output logic [8:0] b1,
                         output logic [8:0] idle);
        logic [8:0] g;
        #3.1;
        repeat (4) tick(1'b1, 1'b1, 1'b1, g);
        tick(~want_id, want_id, 1'b0, b0);
        tick(~want_id, want_id, 1'b0, b1);
        tick(1'b1, 1'b1, 1'b0, idle);
    endtask : frame
endmodule : ebb_analyzer_model
`default_nettype wire

// ### testbench/test_emulation_bus_break_status_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_emulation_bus_break_status_logic;
    logic clock = 1'b0;
    logic rstn, host_strobe_n, cpu_write_mode_n, address_valid_strobe_n, break_reset_n;
    logic pattern_ram_write_enable_n, control_word_write_n, emu_byte_upper_n;
    logic [7:0] buffered_write_data, emu_status, emulator_identity, link_data;
    logic [7:0] data_byte_mux_out, data_status_mux_out;
    logic [6:0] host_address;
    logic [15:0] host_data_out, emu_data, rd;
    logic [17:0] emu_address;
    logic [4:0] cable_sense_n;
    logic host_data_oe_n, analysis_clock, pv_strobe_n, break_strobe, stimulus_event;
    logic interface_halt_pair, interface_halt_pair_n, break_request_n, link_data_oe_n;
    logic transfer_clock_n, identity_select_n, preprocessor_status_select_n;
    logic halt_qualify_clock_n, halt_qualified, emulator_identity_clock_n;
    logic [8:0] b0, b1, bi;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 clock = ~clock;
    ebb_top dut (.clock, .rstn, .transfer_clock_n, .host_strobe_n, .cpu_write_mode_n,
        .address_valid_strobe_n, .pattern_ram_write_enable_n, .control_word_write_n,
        .buffered_write_data, .host_address, .break_reset_n, .host_data_out, .host_data_oe_n,
        .emu_address, .emu_data, .emu_status, .emu_byte_upper_n, .analysis_clock,
        .pv_strobe_n, .cable_sense_n, .emulator_identity, .break_strobe, .stimulus_event,
        .interface_halt_pair, .interface_halt_pair_n, .break_request_n, .data_byte_mux_out,
        .data_status_mux_out, .identity_select_n, .preprocessor_status_select_n,
        .halt_qualify_clock_n, .halt_qualified, .emulator_identity_clock_n, .link_data,
        .link_data_oe_n);
    ebb_analyzer_model u_an (.transfer_clock_n, .identity_select_n,
        .preprocessor_status_select_n, .halt_qualify_clock_n, .halt_qualified,
        .emulator_identity_clock_n, .link_data, .link_data_oe_n);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // Write of pattern RAM or, with cw set, of the control word
    task automatic host_write(input logic [6:0] a, input logic [7:0] d, input logic cw);
        @(posedge clock);
        host_address <= a;
        buffered_write_data <= d;
        cpu_write_mode_n <= 1'b0;
        address_valid_strobe_n <= 1'b0;
        host_strobe_n <= 1'b0;
        pattern_ram_write_enable_n <= cw;
        control_word_write_n <= ~cw;
        repeat (5) @(posedge clock);
        host_strobe_n <= 1'b1;
        address_valid_strobe_n <= 1'b1;
        pattern_ram_write_enable_n <= 1'b1;
        control_word_write_n <= 1'b1;
        cpu_write_mode_n <= 1'b1;
        repeat (5) @(posedge clock);
    endtask : host_write
    task automatic host_read(input logic [6:0] a, output logic [15:0] d);
        int n;
        @(posedge clock);
        host_address <= a;
        address_valid_strobe_n <= 1'b0;
        host_strobe_n <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (host_data_oe_n !== 1'b0 && n < 10);
        @(posedge clock);
        d = host_data_out;
        check({15'h0000, host_data_oe_n}, 16'h0000);
        host_strobe_n <= 1'b1;
        address_valid_strobe_n <= 1'b1;
        repeat (6) @(posedge clock);
    endtask : host_read
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_status();
        host_read(7'h40, rd);
        check(rd & 16'h40FF, 16'h007F);
        check({15'h0000, break_request_n}, 16'h0001);
        $display("reset status done");
    endtask : t_reset_status
    task automatic t_link();
        u_an.frame(1'b1, b0, b1, bi);
        check({7'h00, b0}, {8'h00, ebb_pkg::ID_CODE});
        check({7'h00, b1}, {8'h00, emulator_identity});
        check({15'h0000, bi[8]}, 16'h0001);
        u_an.frame(1'b0, b0, b1, bi);
        check({7'h00, b0}, 16'h007F);
        check({7'h00, b1} & 16'h01C0, 16'h0000);
        $display("link done");
    endtask : t_link
    task automatic t_pattern();
        host_write(7'h05, 8'hE7, 1'b0);
        host_write(7'h3F, 8'h19, 1'b0);
        host_read(7'h05, rd);
        check(rd, 16'h0027);
        host_read(7'h3F, rd);
        check(rd, 16'h0019);
        $display("pattern ram done");
    endtask : t_pattern
    task automatic t_routing();
        emu_data <= 16'hA5C3;
        emu_status <= 8'h3C;
        emu_byte_upper_n <= 1'b0;
        host_write(7'h00, 8'hCF, 1'b1);
        analysis_clock <= 1'b1;
        repeat (5) @(posedge clock);
        analysis_clock <= 1'b0;
        repeat (5) @(posedge clock);
        check({8'h00, data_byte_mux_out}, 16'h00C3);
        check({8'h00, data_status_mux_out}, 16'h00A5);
        host_write(7'h00, 8'hFF, 1'b1);
        analysis_clock <= 1'b1;
        repeat (5) @(posedge clock);
        analysis_clock <= 1'b0;
        repeat (5) @(posedge clock);
        check({8'h00, data_byte_mux_out}, 16'h00A5);
        check({8'h00, data_status_mux_out}, 16'h003C);
        host_read(7'h40, rd);
        check(rd & 16'h8000, 16'h8000);
        // Load mode: strobe clock and latched host address
        host_write(7'h2A, 8'h0F, 1'b1);
        pv_strobe_n <= 1'b0;
        repeat (5) @(posedge clock);
        pv_strobe_n <= 1'b1;
        repeat (5) @(posedge clock);
        check({8'h00, data_byte_mux_out}, 16'h002A);
        check({8'h00, data_status_mux_out}, 16'h0000);
        $display("routing done");
    endtask : t_routing
    task automatic t_breaks();
        logic [7:0] cws [4] = '{8'hF6, 8'hFE, 8'hFA, 8'hF7};
        logic brk [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic [15:0] sw [4] = '{16'h407A, 16'h007F, 16'h007A, 16'h007F};
        for (int i = 0; i < 4; i++)
        begin
            host_write(7'h00, cws[i], 1'b1);
            stimulus_event <= (i != 2);
            interface_halt_pair <= (i == 2);
            interface_halt_pair_n <= (i != 2);
            repeat (6) @(posedge clock);
            check({15'h0000, break_request_n}, {15'h0000, brk[i]});
            stimulus_event <= 1'b0;
            interface_halt_pair <= 1'b0;
            interface_halt_pair_n <= 1'b1;
            host_read(7'h40, rd);
            check(rd & 16'h40FF, sw[i]);
            break_reset_n <= 1'b0;
            repeat (5) @(posedge clock);
            break_reset_n <= 1'b1;
            repeat (5) @(posedge clock);
            check({15'h0000, break_request_n}, 16'h0001);
        end
        $display("breaks done");
    endtask : t_breaks
    task automatic t_pattern_break();
        host_write(7'h3F, 8'h3F, 1'b0);
        host_write(7'h00, 8'hFC, 1'b1);
        emu_address <= 18'h3_FFFF;
        emu_data <= 16'h3F3F;
        emu_status <= 8'h3F;
        host_read(7'h40, rd);
        check(rd & 16'h3F00, 16'h0000);
        break_strobe <= 1'b1;
        repeat (6) @(posedge clock);
        check({15'h0000, break_request_n}, 16'h0000);
        break_strobe <= 1'b0;
        emu_status <= 8'h00;
        host_read(7'h40, rd);
        check(rd & 16'h3FFF, 16'h207C);
        break_reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        break_reset_n <= 1'b1;
        repeat (5) @(posedge clock);
        check({15'h0000, break_request_n}, 16'h0001);
        $display("pattern break done");
    endtask : t_pattern_break
    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    initial
    begin
        rstn = 1'b0;
        {host_strobe_n, cpu_write_mode_n, address_valid_strobe_n, break_reset_n} = 4'hF;
        {pattern_ram_write_enable_n, control_word_write_n, emu_byte_upper_n} = 3'h7;
        {analysis_clock, break_strobe, stimulus_event, interface_halt_pair} = 4'h0;
        pv_strobe_n = 1'b1;
        interface_halt_pair_n = 1'b1;
        buffered_write_data = 8'h00;
        host_address = 7'h00;
        emu_address = 18'h0_0000;
        emu_data = 16'h0000;
        emu_status = 8'h00;
        cable_sense_n = 5'h00;
        emulator_identity = 8'h6C;
        // One link edge inside reset so the link side is surely reset
        fork
            u_an.tick(1'b1, 1'b1, 1'b0, bi);
            repeat (5) @(posedge clock);
        join
        @(posedge clock);
        rstn <= 1'b1;
        // Link reset needs two link edges to release; keep selects idle meanwhile
        repeat (3) u_an.tick(1'b1, 1'b1, 1'b0, bi);
        repeat (5) @(posedge clock);
        t_reset_status();
        t_link();
        t_pattern();
        t_routing();
        t_breaks();
        t_pattern_break();
        end_of_test();
    end
endmodule : test_emulation_bus_break_status_logic
`default_nettype wire
